// ===== dv/mcss_checker_assertions.sv
// concurrent checks on the misstep and sensor stop block ports
`timescale 1ns/1ps
module mcss_checker (
    input wire        CLOCK_I,          // clock
    input wire        RST_B_I,          // sync reset, low
    input wire        CE_I,             // clock enable
    input wire        CONT_MOVE_I,      // continuous move
    input wire        HOME_SEEK_I,      // home seek
    input wire        MOVING_I,         // in motion
    input wire        MECH_HOME_I,      // mechanical home
    input wire        MOTION_CMD_I,     // motion command
    input wire        STEPOUT_RAW_I,    // raw stepout
    input wire        SLOW_TO_START_O,  // slow down
    input wire        RETURN_MOVE_O,    // return move
    input wire [24:0] RETURN_TARGET_O,  // return target
    input wire        STANDSTILL_CUR_O, // standstill current
    input wire        HARD_STOP_O,      // hard stop
    input wire        SOFT_STOP_O,      // soft stop
    input wire        OFFSET_STOP_O,    // offset stop
    input wire [18:0] OFFSET_VEL_O,     // offset velocity
    input wire        STEPOUT_O,        // gated stepout
    input wire        ALARM_MOTION_O,   // motion alarm
    input wire        ALARM_OVERLOAD_O  // overload alarm
);
    // any stop request at all
    wire stop = HARD_STOP_O | SOFT_STOP_O | OFFSET_STOP_O;

    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);

    AST_STEPOUT_GATED: assert property (CE_I && !STEPOUT_RAW_I |=> !STEPOUT_O)
        else $error("stepout output without raw stepout");
    AST_STOP_ONE: assert property ($onehot0({HARD_STOP_O, SOFT_STOP_O, OFFSET_STOP_O}))
        else $error("more than one stop request");
    AST_STOP_PULSE: assert property (CE_I && stop |=> !stop)
        else $error("stop request longer than one cycle");
    AST_STOP_CONT: assert property (stop |-> $past(CONT_MOVE_I)
        && !$past(HOME_SEEK_I)) else $error("stop request outside continuous move");
    AST_VEL_RANGE: assert property (OFFSET_VEL_O >= 19'h0_0001 && OFFSET_VEL_O <= 19'h7_A120)
        else $error("offset velocity out of range");
    AST_RET_CURRENT: assert property (RETURN_MOVE_O |-> STANDSTILL_CUR_O)
        else $error("return move without standstill current");
    AST_RET_RANGE: assert property ($rose(RETURN_MOVE_O) |-> RETURN_TARGET_O[24:23] == 2'b00
        || (RETURN_TARGET_O[24:23] == 2'b11 && RETURN_TARGET_O != 25'h180_0000))
        else $error("return move with position out of range");
    AST_NO_MECH: assert property ($rose(RETURN_MOVE_O) || $rose(SLOW_TO_START_O)
        |-> !$past(MECH_HOME_I)) else $error("correction during home return");
    AST_SLOW_MOVING: assert property ($rose(SLOW_TO_START_O) |-> $past(MOVING_I))
        else $error("slow down while at rest");
    AST_ALARM_STICKY: assert property (!$fell(ALARM_MOTION_O) && !$fell(ALARM_OVERLOAD_O))
        else $error("alarm cleared without reset");
    AST_ALARM_CAUSE: assert property ($rose(ALARM_MOTION_O)
        |-> $past(MOTION_CMD_I, 2) && $past(RETURN_MOVE_O, 2))
        else $error("motion alarm without cause");
endmodule // mcss_checker

bind mcss_top mcss_checker u_chk (.CLOCK_I, .RST_B_I, .CE_I, .CONT_MOVE_I, .MOVING_I,
    .HOME_SEEK_I, .MECH_HOME_I, .MOTION_CMD_I, .STEPOUT_RAW_I, .SLOW_TO_START_O, .RETURN_MOVE_O,
    .RETURN_TARGET_O, .STANDSTILL_CUR_O, .HARD_STOP_O, .SOFT_STOP_O, .OFFSET_STOP_O,
    .OFFSET_VEL_O, .STEPOUT_O, .ALARM_MOTION_O, .ALARM_OVERLOAD_O);

// ===== dv/mcss_motor_model.sv
// far side model: sensor wiring and encoder counter
`timescale 1ns/1ps
module mcss_motor_model (
    input  wire        clk_i,            // clock
    input  wire        sensor_on_i,      // target at sensor
    input  wire        sensor_pol_i,     // 1: normally closed
    input  wire [24:0] cmd_pos_i,        // command position
    input  wire [24:0] slip_i,           // missed steps
    output reg         pin_o = 1'b0,     // raw sensor pin
    output reg  [24:0] enc_o = 25'h000_0000 // encoder counter
);
    // closed wiring idles high; encoder lags the shaft by one cycle
    always @(posedge clk_i) begin
        pin_o <= sensor_on_i ^ sensor_pol_i;
        enc_o <= cmd_pos_i + slip_i;
    end
endmodule // mcss_motor_model

// ===== dv/misstep_correct_sensor_stop_test.sv
// self-checking bench for the misstep and sensor stop block
`timescale 1ns/1ps
module misstep_correct_sensor_stop_test;
    reg         clk, rst_b, ce, wr, rd, moving, cont, home, mech, mcmd, son, spol, sraw;
    reg  [3:0]  addr;
    reg  [31:0] wdata;
    reg  [24:0] cmd, slip;
    wire [31:0] rdata;
    wire [24:0] rtgt, otgt, enc;
    wire [18:0] ovel;
    wire        slow, ret, scur, hard_stop_command, soft_stop_command, ostop, stepout_output, cstat, amot, aovl, pin;
    wire [3:0]  mon = {aovl, amot, slow, ret};
    integer     errors = 0;
    integer     comparisons = 0;

    mcss_motor_model model (.clk_i(clk), .sensor_on_i(son), .sensor_pol_i(spol),
        .cmd_pos_i(cmd), .slip_i(slip), .pin_o(pin), .enc_o(enc));
    // short millisecond tick keeps the timeout test brief
    mcss_top #(.MS_CYC(10)) dut (.CLOCK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CMD_POS_I(cmd),
        .ENC_CNT_I(enc), .MOVING_I(moving), .CONT_MOVE_I(cont), .HOME_SEEK_I(home),
        .MECH_HOME_I(mech), .MOTION_CMD_I(mcmd), .SENSOR_PIN_I(pin), .STEPOUT_RAW_I(sraw),
        .SLOW_TO_START_O(slow), .RETURN_MOVE_O(ret), .RETURN_TARGET_O(rtgt),
        .STANDSTILL_CUR_O(scur), .HARD_STOP_O(hard_stop_command), .SOFT_STOP_O(soft_stop_command),
        .OFFSET_STOP_O(ostop), .OFFSET_TARGET_O(otgt), .OFFSET_VEL_O(ovel),
        .STEPOUT_O(stepout_output), .CORR_STATUS_O(cstat), .ALARM_MOTION_O(amot),
        .ALARM_OVERLOAD_O(aovl));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // bus cycles: strobe for one cycle, read data in the next cycle only
    task wr_reg(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            #1;
        end
    endtask
    task rd_reg(input [3:0] a, input [31:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            chk(rdata, exp);
        end
    endtask
    task do_reset;
        begin
            @(posedge clk);
            rst_b <= 1'b0;
            repeat (2) @(posedge clk);
            rst_b <= 1'b1;
        end
    endtask
    // reset-applied settings need a reset to take hold
    task cfg(input [4:0] c);
        begin
            wr_reg(4'h0, {27'h000_0000, c});
            do_reset;
        end
    endtask
    task settle;
        begin
            repeat (20) @(posedge clk);
            #1;
        end
    endtask
    task wait_on(input integer i);
        integer n;
        begin
            n = 0;
            while (mon[i] !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            chk(mon[i], 1);
        end
    endtask
    task stops(input [2:0] exp);
        reg [2:0] acc;
        begin
            acc = 3'h0;
            repeat (12) begin
                @(posedge clk);
                #1;
                acc = acc | {ostop, soft_stop_command, hard_stop_command};
            end
            chk(acc, exp);
        end
    endtask

    task test_defaults;
        begin
            rd_reg(4'h1, 32'h0000_03E8);
            rd_reg(4'h3, 32'h0000_03E8);
            chk(ovel, 32'h0000_03E8);
            rd_reg(4'h4, 32'h0000_01F4);
            rd_reg(4'h6, 32'h0000_0032);
            rd_reg(4'h7, 32'h0000_0064);
            rd_reg(4'hF, 32'h0000_0000);
            wr_reg(4'h0, 32'h0000_0001);
            wr_reg(4'h0, 32'h0000_0019);
            rd_reg(4'h0, 32'h0000_0001);
            rd_reg(4'h9, 32'h0000_0010);
            do_reset;
            rd_reg(4'h9, 32'h0000_0001);
            wr_reg(4'h3, 32'h0000_0000);
            rd_reg(4'h3, 32'h0000_03E8);
            wr_reg(4'h3, 32'h0007_A120);
            rd_reg(4'h3, 32'h0007_A120);
            chk(ovel, 32'h0007_A120);
            wr_reg(4'h2, 32'h007F_FFFF);
            wr_reg(4'h2, 32'h0080_0000);
            rd_reg(4'h2, 32'h007F_FFFF);
            wr_reg(4'h1, 32'h0000_2711);
            wr_reg(4'h1, 32'h0000_2710);
            rd_reg(4'h1, 32'h0000_2710);
            $display("test registers done");
        end
    endtask
    // every stop action once, the middle one with closed sensor wiring
    task test_sensor;
        integer a;
        begin
            for (a = 0; a < 3; a = a + 1) begin
                @(posedge clk);
                spol <= a[0];
                son <= 1'b0;
                cont <= 1'b0;
                cfg({a[1:0], a[0], 2'b00});
                wr_reg(4'h2, 32'h0000_012C);
                @(posedge clk);
                cmd <= 25'h000_03E8;
                cont <= 1'b1;
                son <= 1'b1;
                stops(3'b001 << a);
                chk(otgt, (a == 2) ? 32'h0000_0514 : 32'h0000_0000);
            end
            @(posedge clk);
            son <= 1'b0;
            cont <= 1'b0;
            repeat (4) @(posedge clk);
            son <= 1'b1;
            stops(3'b000);
            @(posedge clk);
            son <= 1'b0;
            cont <= 1'b1;
            home <= 1'b1;
            repeat (4) @(posedge clk);
            son <= 1'b1;
            stops(3'b000);
            @(posedge clk);
            son <= 1'b0;
            cont <= 1'b0;
            home <= 1'b0;
            $display("test sensor done");
        end
    endtask
    task test_standstill;
        begin
            cfg(5'h03);
            wr_reg(4'h1, 32'h0000_0001);
            chk(cstat, 1);
            @(posedge clk);
            cmd <= 25'h000_0064;
            slip <= 25'h000_0033;
            sraw <= 1'b1;
            wait_on(0);
            // status follows the state one cycle later
            @(posedge clk);
            #1;
            chk({scur, stepout_output, cstat, rtgt}, 32'h0800_0064);
            @(posedge clk);
            mcmd <= 1'b1;
            @(posedge clk);
            mcmd <= 1'b0;
            wait_on(2);
            wait_on(3);
            $display("test standstill done");
        end
    endtask
    task test_moving;
        begin
            @(posedge clk);
            slip <= 25'h000_0000;
            mech <= 1'b1;
            cfg(5'h01);
            @(posedge clk);
            slip <= 25'h000_003C;
            settle;
            chk({slow, ret}, 0);
            @(posedge clk);
            mech <= 1'b0;
            moving <= 1'b1;
            wait_on(1);
            @(posedge clk);
            moving <= 1'b0;
            slip <= 25'h000_0000;
            cfg(5'h01);
            wr_reg(4'h4, 32'h0000_03E8);
            @(posedge clk);
            slip <= 25'h000_0064;
            settle;
            chk(ret, 0);
            @(posedge clk);
            slip <= 25'h000_0065;
            wait_on(0);
            @(posedge clk);
            slip <= 25'h000_0000;
            cmd <= 25'h080_0000;
            cfg(5'h01);
            slip <= 25'h000_003C;
            settle;
            chk(ret, 0);
            @(posedge clk);
            cmd <= 25'h180_0000;
            settle;
            chk(ret, 0);
            @(posedge clk);
            cmd <= 25'h180_0001;
            wait_on(0);
            @(posedge clk);
            cmd <= 25'h000_0064;
            cfg(5'h00);
            settle;
            chk({stepout_output, slow, ret}, 3'b100);
            $display("test moving done");
        end
    endtask

    task print_verdict;
        begin
            $display("comparisons=%0d errors=%0d", comparisons, errors);
            if (errors == 0 && comparisons > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask

    // tests need a few hundred cycles; allow over a hundred times that
    initial begin
        #500000;
        errors = errors + 1;
        print_verdict;
    end

    initial begin
        {rst_b, wr, rd, moving, cont, home, mech, mcmd, son, spol, sraw} = 11'h000;
        ce = 1'b1;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        cmd = 25'h000_0000;
        slip = 25'h000_0000;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        cfg(5'h10);
        test_defaults;
        test_sensor;
        test_standstill;
        test_moving;
        print_verdict;
    end
endmodule // misstep_correct_sensor_stop_test

// ===== hw/mcss_defs.vh
// constants for the misstep-correction and sensor-stop block
`ifndef MCSS_DEFS_VH
`define MCSS_DEFS_VH
// register offsets
`define MCSS_A_CTRL      4'h0
`define MCSS_A_TIMEOUT   4'h1
`define MCSS_A_OFS_DIST  4'h2
`define MCSS_A_OFS_VEL   4'h3
`define MCSS_A_EGB       4'h4
`define MCSS_A_MOTOR_RESOLUTION      4'h5
`define MCSS_A_THR_072   4'h6
`define MCSS_A_THR_036   4'h7
`define MCSS_A_STATUS    4'h8
`define MCSS_A_ACTIVE    4'h9
// control field positions (pending copies)
`define MCSS_B_EN        0
`define MCSS_B_OPOL      1
`define MCSS_B_SPOL      2
`define MCSS_B_ACT_LO    3
`define MCSS_B_ACT_HI    4
// reset values
`define MCSS_RV_EN       1'b0
`define MCSS_RV_OPOL     1'b0
`define MCSS_RV_SPOL     1'b0
`define MCSS_RV_ACT      2'h2
`define MCSS_RV_TO_MS    14'h03E8
`define MCSS_RV_OFS_VEL  19'h0_03E8
`define MCSS_RV_EGB      16'h01F4
`define MCSS_RV_THR_072  24'h00_0032
`define MCSS_RV_THR_036  24'h00_0064
// limits
`define MCSS_TO_MAX_MS   14'h2710
`define MCSS_VEL_MAX     19'h7_A120
`define MCSS_POS_MAX     24'h7F_FFFF
`define MCSS_EGB_072     16'h01F4
`define MCSS_EGB_036     16'h03E8
// timing: one millisecond tick
`define MCSS_MS_NS       1000000
`define MCSS_CLK_NS      10
`define MCSS_MS_CYC      (`MCSS_MS_NS / `MCSS_CLK_NS)
// stop actions
`define MCSS_ACT_HARD    2'h0
`define MCSS_ACT_SOFT    2'h1
`define MCSS_ACT_OFFSET  2'h2
`endif

// ===== hw/mcss_top.v
// misstep self-correction and sensor stop action block
//
// Operation
// - correction enable, default off, applies after reset; pending copy has no reset value, so no default here
// - compare command position with encoder counter
// - moving misstep: slow to starting velocity, resume
// - standstill misstep: return to original position
// - use standstill current during return move
// - skip return when position beyond 8388607
// - threshold chosen by gear B and resolution
// - no correction during mechanical home return
// - correction enabled disables stepout output
// - motion command during return raises alarm
// - overload beyond timeout raises alarm
// - correction output polarity, applies after reset
// - offset distance 0..8388607, immediate
// - offset velocity 1..500000, default 1000, immediate
// - sensor action only in continuous motion
// - action 0 requests hard stop
// - action 1 requests soft stop
// - action 2 offset velocity then stop at distance
// - home seek ignores sensor stop action
// - sensor polarity, default normally open; pending copy has no reset value, so no default here
// - reset settings stored, applied after reset
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "mcss_defs.vh"

module mcss_top #(
    parameter MS_CYC = `MCSS_MS_CYC              // cycles per millisecond tick
) (
    input  wire        CLOCK_I,                  // 100 MHz clock
    input  wire        RST_B_I,                  // synchronous reset, low
    input  wire        CE_I,                     // clock enable
    input  wire [3:0]  ADDR_I,                   // register index
    input  wire [31:0] WDATA_I,                  // write data
    input  wire        WR_I,                     // write strobe
    input  wire        RD_I,                     // read strobe
    output reg  [31:0] RDATA_O,                  // read data, one cycle later
    input  wire [24:0] CMD_POS_I,                // command position, signed
    input  wire [24:0] ENC_CNT_I,                // encoder counter, signed
    input  wire        MOVING_I,                 // profile generator in motion
    input  wire        CONT_MOVE_I,              // continuous move running
    input  wire        HOME_SEEK_I,              // home seeking running
    input  wire        MECH_HOME_I,              // mechanical home return running
    input  wire        MOTION_CMD_I,             // new motion command pulse
    input  wire        SENSOR_PIN_I,             // raw sensor pin
    input  wire        STEPOUT_RAW_I,            // stepout detector result
    output reg         SLOW_TO_START_O,          // slow to starting velocity
    output reg         RETURN_MOVE_O,            // return to original position
    output reg  [24:0] RETURN_TARGET_O,          // original position to return to
    output reg         STANDSTILL_CUR_O,         // select standstill current
    output reg         HARD_STOP_O,              // hard stop request pulse
    output reg         SOFT_STOP_O,              // soft stop request pulse
    output reg         OFFSET_STOP_O,            // offset stop request pulse
    output reg  [24:0] OFFSET_TARGET_O,          // stop position for offset stop
    output reg  [18:0] OFFSET_VEL_O,             // offset velocity
    output reg         STEPOUT_O,                // gated stepout output
    output reg         CORR_STATUS_O,            // correction status, polarised
    output reg         ALARM_MOTION_O,           // motion while in motion alarm
    output reg         ALARM_OVERLOAD_O          // correction overload alarm
);

    localparam ST_IDLE = 2'h0;
    localparam ST_SLOW = 2'h1;
    localparam ST_RET  = 2'h2;

    // pending copies written by software, saved across reset
    reg        pend_en;
    reg        pend_opol;
    reg        pend_spol;
    reg [1:0]  pend_act;
    // active copies loaded at reset
    reg        act_en;
    reg        act_opol;
    reg        act_spol;
    reg [1:0]  act_act;
    // immediate settings
    reg [13:0] timeout_ms;
    reg [23:0] ofs_dist;
    reg [18:0] ofs_vel;
    reg [15:0] encoder_gear_b;
    reg [3:0]  motor_resolution;
    reg [23:0] thr_072;
    reg [23:0] thr_036;
    // state
    reg [1:0]  state;
    reg        sens_s1;
    reg        sens_s2;
    reg        sens_q;
    reg [23:0] ms_cnt;
    reg [13:0] over_ms;
    reg        ovl_alarm;
    reg        mot_alarm;

    wire        wr_ok = CE_I & WR_I;
    wire [24:0] dev = CMD_POS_I - ENC_CNT_I;
    wire [24:0] adev = dev[24] ? (~dev + 25'h000_0001) : dev;
    wire [23:0] thr;
    wire        thr_known;
    wire        misstep;
    wire        pos_ok;
    wire        sens_act;
    wire        sens_edge;

    // threshold selected from the gear setting; unknown motor never trips
    assign thr_known = (motor_resolution == 4'h0) &&
                       ((encoder_gear_b == `MCSS_EGB_072) || (encoder_gear_b == `MCSS_EGB_036));
    assign thr = (encoder_gear_b == `MCSS_EGB_036) ? thr_036 : thr_072;
    assign misstep = act_en & ~MECH_HOME_I & thr_known &
                     (adev > {1'b0, thr});
    // return only when command position stays within 24-bit magnitude
    // the most negative 24-bit value is outside the symmetric range as well
    assign pos_ok = (CMD_POS_I[24:23] == 2'b00) ||
                    ((CMD_POS_I[24:23] == 2'b11) && (CMD_POS_I[22:0] != 23'h00_0000));
    assign sens_act  = sens_s2 ^ act_spol;
    assign sens_edge = sens_act & ~sens_q;

    // register writes; pending copies survive reset, live ones take defaults
    always @(posedge CLOCK_I) begin
        if (wr_ok && ADDR_I == `MCSS_A_CTRL) begin
            pend_en   <= WDATA_I[`MCSS_B_EN];
            pend_opol <= WDATA_I[`MCSS_B_OPOL];
            pend_spol <= WDATA_I[`MCSS_B_SPOL];
            pend_act  <= (WDATA_I[`MCSS_B_ACT_HI:`MCSS_B_ACT_LO] == 2'h3) ?
                         pend_act : WDATA_I[`MCSS_B_ACT_HI:`MCSS_B_ACT_LO];
        end
    end

    // active copies follow pending only at reset
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            act_en   <= pend_en;
            act_opol <= pend_opol;
            act_spol <= pend_spol;
            act_act  <= pend_act;
        end
    end

    // immediate settings, out-of-range timeout, offset distance and offset velocity writes are ignored
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            timeout_ms <= `MCSS_RV_TO_MS;
            ofs_dist   <= 24'h00_0000;
            ofs_vel    <= `MCSS_RV_OFS_VEL;
            encoder_gear_b        <= `MCSS_RV_EGB;
            motor_resolution       <= 4'h0;
            thr_072    <= `MCSS_RV_THR_072;
            thr_036    <= `MCSS_RV_THR_036;
        end else if (wr_ok) begin
            if (ADDR_I == `MCSS_A_TIMEOUT) begin
                if (WDATA_I[31:14] == 18'h0_0000 && WDATA_I[13:0] <= `MCSS_TO_MAX_MS)
                    timeout_ms <= WDATA_I[13:0];
            end else if (ADDR_I == `MCSS_A_OFS_DIST) begin
                if (WDATA_I[31:24] == 8'h00 && WDATA_I[23:0] <= `MCSS_POS_MAX)
                    ofs_dist <= WDATA_I[23:0];
            end else if (ADDR_I == `MCSS_A_OFS_VEL) begin
                if (WDATA_I[31:19] == 13'h0000 && WDATA_I[18:0] != 19'h0_0000 &&
                    WDATA_I[18:0] <= `MCSS_VEL_MAX)
                    ofs_vel <= WDATA_I[18:0];
            end else if (ADDR_I == `MCSS_A_EGB) begin
                encoder_gear_b <= WDATA_I[15:0];
            end else if (ADDR_I == `MCSS_A_MOTOR_RESOLUTION) begin
                motor_resolution <= WDATA_I[3:0];
            end else if (ADDR_I == `MCSS_A_THR_072) begin
                thr_072 <= WDATA_I[23:0];
            end else if (ADDR_I == `MCSS_A_THR_036) begin
                thr_036 <= WDATA_I[23:0];
            end
        end
    end

    // read port; unmapped indices read zero
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            RDATA_O <= 32'h0000_0000;
        end else if (CE_I) begin
            if (!RD_I)
                RDATA_O <= 32'h0000_0000;
            else if (ADDR_I == `MCSS_A_CTRL)
                RDATA_O <= {27'h000_0000, pend_act, pend_spol, pend_opol, pend_en};
            else if (ADDR_I == `MCSS_A_TIMEOUT)
                RDATA_O <= {18'h0_0000, timeout_ms};
            else if (ADDR_I == `MCSS_A_OFS_DIST)
                RDATA_O <= {8'h00, ofs_dist};
            else if (ADDR_I == `MCSS_A_OFS_VEL)
                RDATA_O <= {13'h0000, ofs_vel};
            else if (ADDR_I == `MCSS_A_EGB)
                RDATA_O <= {16'h0000, encoder_gear_b};
            else if (ADDR_I == `MCSS_A_MOTOR_RESOLUTION)
                RDATA_O <= {28'h000_0000, motor_resolution};
            else if (ADDR_I == `MCSS_A_THR_072)
                RDATA_O <= {8'h00, thr_072};
            else if (ADDR_I == `MCSS_A_THR_036)
                RDATA_O <= {8'h00, thr_036};
            else if (ADDR_I == `MCSS_A_STATUS)
                RDATA_O <= {26'h000_0000, mot_alarm, ovl_alarm, sens_act,
                            misstep, state};
            else if (ADDR_I == `MCSS_A_ACTIVE)
                RDATA_O <= {27'h000_0000, act_act, act_spol, act_opol, act_en};
            else
                RDATA_O <= 32'h0000_0000;
        end
    end

    // sensor pin synchroniser, then a single edge register
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            sens_s1 <= 1'b0;
            sens_s2 <= 1'b0;
            sens_q  <= 1'b1;                       // closed wiring must not fake an edge
        end else if (CE_I) begin
            sens_s1 <= SENSOR_PIN_I;
            sens_s2 <= sens_s1;
            sens_q  <= sens_act;
        end
    end

    // sensor stop: only continuous moves, home seek keeps its own use
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            HARD_STOP_O     <= 1'b0;
            SOFT_STOP_O     <= 1'b0;
            OFFSET_STOP_O   <= 1'b0;
            OFFSET_TARGET_O <= 25'h000_0000;
            OFFSET_VEL_O    <= `MCSS_RV_OFS_VEL;
        end else if (CE_I) begin
            OFFSET_VEL_O  <= ofs_vel;
            HARD_STOP_O   <= 1'b0;
            SOFT_STOP_O   <= 1'b0;
            OFFSET_STOP_O <= 1'b0;
            if (sens_edge && CONT_MOVE_I && !HOME_SEEK_I) begin
                if (act_act == `MCSS_ACT_HARD)
                    HARD_STOP_O <= 1'b1;
                else if (act_act == `MCSS_ACT_SOFT)
                    SOFT_STOP_O <= 1'b1;
                else begin
                    OFFSET_STOP_O <= 1'b1;
                    // direction from sign of the remaining travel is unknown here,
                    // so the profile takes the magnitude; target given for + direction
                    OFFSET_TARGET_O <= CMD_POS_I + {1'b0, ofs_dist};
                end
            end
        end
    end

    // correction sequencer
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            state            <= ST_IDLE;
            SLOW_TO_START_O  <= 1'b0;
            RETURN_MOVE_O    <= 1'b0;
            RETURN_TARGET_O  <= 25'h000_0000;
            STANDSTILL_CUR_O <= 1'b0;
            mot_alarm        <= 1'b0;
        end else if (CE_I) begin
            case (state)
                ST_IDLE: begin
                    if (misstep && MOVING_I) begin
                        state           <= ST_SLOW;
                        SLOW_TO_START_O <= 1'b1;
                    end else if (misstep && pos_ok) begin
                        state            <= ST_RET;
                        RETURN_MOVE_O    <= 1'b1;
                        RETURN_TARGET_O  <= CMD_POS_I;
                        STANDSTILL_CUR_O <= 1'b1;
                    end
                end
                ST_SLOW: begin
                    // profile resumes once deviation is back inside the band
                    if (!misstep || !MOVING_I) begin
                        state           <= ST_IDLE;
                        SLOW_TO_START_O <= 1'b0;
                    end
                end
                ST_RET: begin
                    if (MOTION_CMD_I)
                        mot_alarm <= 1'b1;
                    if (!misstep || MECH_HOME_I) begin
                        state            <= ST_IDLE;
                        RETURN_MOVE_O    <= 1'b0;
                        STANDSTILL_CUR_O <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // overload timer: misstep that outlasts the timeout latches the alarm
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            ms_cnt    <= 24'h00_0000;
            over_ms   <= 14'h0000;
            ovl_alarm <= 1'b0;
        end else if (CE_I) begin
            if (!misstep) begin
                ms_cnt  <= 24'h00_0000;
                over_ms <= 14'h0000;
            end else if (over_ms >= timeout_ms) begin
                ovl_alarm <= 1'b1;
            end else if (ms_cnt == MS_CYC - 1) begin
                ms_cnt  <= 24'h00_0000;
                over_ms <= over_ms + 14'h0001;
            end else begin
                ms_cnt <= ms_cnt + 24'h00_0001;
            end
        end
    end

    // status outputs
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            STEPOUT_O        <= 1'b0;
            CORR_STATUS_O    <= 1'b0;
            ALARM_MOTION_O   <= 1'b0;
            ALARM_OVERLOAD_O <= 1'b0;
        end else if (CE_I) begin
            STEPOUT_O        <= STEPOUT_RAW_I & ~act_en;
            CORR_STATUS_O    <= (state != ST_IDLE) ^ act_opol;
            ALARM_MOTION_O   <= mot_alarm;
            ALARM_OVERLOAD_O <= ovl_alarm;
        end
    end

endmodule // mcss_top
